//--- inc/pae_defs.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * expansion / energy-detect power-down register bank.
 * assumes a 50 MHz core clock.
 */
`ifndef PAE_DEFS_SVH
`define PAE_DEFS_SVH

`define PAE_OFS_EXPANSION   5'h06
`define PAE_OFS_PULSE_CFG   5'h10
`define PAE_OFS_MODE_CTL    5'h11
`define PAE_OFS_INT_SRC     5'h1D

`define PAE_EXP_PDF_BIT     4
`define PAE_EXP_LPNP_BIT    3
`define PAE_EXP_NP_BIT      2
`define PAE_EXP_PR_BIT      1
`define PAE_EXP_LPAN_BIT    0

`define PAE_CFG_TXEN_BIT    15
`define PAE_CFG_TXIV_HI     14
`define PAE_CFG_TXIV_LO     13
`define PAE_CFG_WAKE1_BIT   12
`define PAE_CFG_RXIV_HI     11
`define PAE_CFG_RXIV_LO     10
`define PAE_CFG_XOVER_BIT   0
`define PAE_CFG_WMASK       16'hFC01

`define PAE_MODE_PDEN_BIT   13
`define PAE_MODE_EPRES_BIT  1
`define PAE_MODE_R0_BIT     0

`define PAE_INT_PDF_BIT     2
`define PAE_INT_PR_BIT      1

`define PAE_RST_CFG         16'h0000
`define PAE_RST_NP_ABLE     1'b0

`define PAE_CLK_HZ          50000000
`define PAE_MS_CYC          (`PAE_CLK_HZ / 1000)
`define PAE_T_ENERGY_MS     256
`define PAE_T_XOVER_EXT_MS  1984

`endif

//--- inc/pae_pkg.sv
/*
 * types shared by the expansion / power-down register bank.
 * assumes pae_defs.svh is on the include path.
 */
`default_nettype none
package pae_pkg;
	typedef logic [27:0] pae_cnt_t;

	typedef struct packed {
		logic       pulse_tx_en;
		logic [1:0] pulse_tx_iv;
		logic       wake_single;
		logic [1:0] wake_pair_iv;
		logic       xover_ext;
	} pae_cfg_s;

	typedef enum logic [1:0] {
		PAE_AWAKE,
		PAE_ASLEEP,
		PAE_GOT_ONE
	} pae_pwr_e;
endpackage : pae_pkg
`default_nettype wire

//--- rtl/pae_interval.sv
/*
 * free interval timer: pulses done when the chosen limit in clock cycles elapses.
 * assumes a 50 MHz clock; run low holds it cleared.
 */
`default_nettype none
`include "pae_defs.svh"
module pae_interval
	import pae_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     run,
	input  wire logic     restart,
	input  wire pae_cnt_t limit,
	output logic          done
);
	pae_cnt_t cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (!run || restart || done) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 28'h1;
		end
	end

	assign done = run && !restart && (cnt_q + 28'h1 >= limit);
endmodule : pae_interval
`default_nettype wire

//--- rtl/pae_latch.sv
/*
 * latched-high status flag cleared by a read of its register.
 * an event in the read cycle keeps the flag set.
 */
`default_nettype none
module pae_latch (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic soft_rst,
	input  wire logic event_in,
	input  wire logic rd_clr,
	output logic      flag
);
	logic flag_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (event_in) begin
			flag_q <= 1'b1;
		end else if (rd_clr || soft_rst) begin
			flag_q <= 1'b0;
		end
	end

	assign flag = flag_q;
endmodule : pae_latch
`default_nettype wire

//--- rtl/pae_regs.sv
/*
 * expansion status and energy-detect power-down register bank.
 * assumes a management port giving one-cycle read/write strobes with a
 * 5-bit register index, and line-side events synchronous to CLK.
 */
// Notes on behaviour
// - parallel detection fault latched until read
// - partner next page ability in bit 3
// - local next page ability, resets 0
// - page received latched until read
// - partner auto-negotiation ability in bit 0
// - bit 15 enables periodic power-down pulses
// - bits 14:13 choose pulse spacing
// - bit 12 wakes on one pulse
// - bit 0 extends crossover by 1984 ms
// - power-down only while mode bit 13 set
// - interrupt source flags for fault, page
`default_nettype none
`include "pae_defs.svh"
module pae_regs
	import pae_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        SOFT_RST,
	input  wire logic        REG_RD,
	input  wire logic        REG_WR,
	input  wire logic [4:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	output logic      [15:0] REG_RDATA,
	input  wire logic        PD_FAULT,
	input  wire logic        PAGE_RX,
	input  wire logic        LP_NP_ABLE,
	input  wire logic        LP_AN_ABLE,
	input  wire logic        LINE_ENERGY,
	input  wire logic        RX_PULSE,
	input  wire logic        XOVER_ACTIVE,
	output logic             TX_PULSE,
	output logic             POWERED_DOWN,
	output logic             XOVER_EXTEND,
	output logic             ENERGY_PRESENT
);
	pae_cfg_s  cfg_q;
	logic      pden_q;
	logic      mode_r0_q;
	logic      energy_q;
	pae_pwr_e  pwr_q;
	logic      tx_pulse_q;
	logic      xext_q;
	logic [15:0] rdata_q;
	logic      pdf_flag;
	logic      pr_flag;
	logic      int_pdf;
	logic      int_pr;
	logic      rd_exp;
	logic      rd_int;
	logic      tx_done;
	logic      rx_done;
	logic      quiet_done;
	logic      xo_done;
	logic      sleeping;
	logic      pden_off;

	function automatic pae_cnt_t ms_cyc(input int ms);
		ms_cyc = pae_cnt_t'(ms * `PAE_MS_CYC);
	endfunction : ms_cyc

	function automatic pae_cnt_t tx_limit(input logic [1:0] sel);
		case (sel)
			2'h0:    tx_limit = ms_cyc(1000);
			2'h1:    tx_limit = ms_cyc(768);
			2'h2:    tx_limit = ms_cyc(512);
			default: tx_limit = ms_cyc(256);
		endcase
	endfunction : tx_limit

	function automatic pae_cnt_t rx_limit(input logic [1:0] sel);
		case (sel)
			2'h0:    rx_limit = ms_cyc(64);
			2'h1:    rx_limit = ms_cyc(256);
			2'h2:    rx_limit = ms_cyc(512);
			default: rx_limit = ms_cyc(1000);
		endcase
	endfunction : rx_limit

	assign rd_exp = REG_RD && (REG_ADDR == `PAE_OFS_EXPANSION);
	assign rd_int = REG_RD && (REG_ADDR == `PAE_OFS_INT_SRC);
	assign sleeping = (pwr_q != PAE_AWAKE);
	// leave power-down in the same edge that clears the enable bit
	assign pden_off = REG_WR && (REG_ADDR == `PAE_OFS_MODE_CTL) && !REG_WDATA[`PAE_MODE_PDEN_BIT];

	// latched-high flags
	pae_latch u_pdf (.clk(CLK), .rst(RST), .soft_rst(SOFT_RST), .event_in(PD_FAULT),
		.rd_clr(rd_exp), .flag(pdf_flag));
	pae_latch u_pr (.clk(CLK), .rst(RST), .soft_rst(SOFT_RST), .event_in(PAGE_RX),
		.rd_clr(rd_exp), .flag(pr_flag));
	pae_latch u_ipdf (.clk(CLK), .rst(RST), .soft_rst(SOFT_RST), .event_in(PD_FAULT),
		.rd_clr(rd_int), .flag(int_pdf));
	pae_latch u_ipr (.clk(CLK), .rst(RST), .soft_rst(SOFT_RST), .event_in(PAGE_RX),
		.rd_clr(rd_int), .flag(int_pr));

	// configuration writes
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cfg_q <= pae_cfg_s'(7'h00);
		end else if (SOFT_RST) begin
			cfg_q <= pae_cfg_s'(7'h00);
		end else if (REG_WR && REG_ADDR == `PAE_OFS_PULSE_CFG) begin
			cfg_q.pulse_tx_en  <= REG_WDATA[`PAE_CFG_TXEN_BIT];
			cfg_q.pulse_tx_iv  <= REG_WDATA[`PAE_CFG_TXIV_HI:`PAE_CFG_TXIV_LO];
			cfg_q.wake_single  <= REG_WDATA[`PAE_CFG_WAKE1_BIT];
			cfg_q.wake_pair_iv <= REG_WDATA[`PAE_CFG_RXIV_HI:`PAE_CFG_RXIV_LO];
			cfg_q.xover_ext    <= REG_WDATA[`PAE_CFG_XOVER_BIT];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pden_q    <= 1'b0;
			mode_r0_q <= 1'b0;
		end else if (SOFT_RST) begin
			pden_q    <= 1'b0;
			mode_r0_q <= 1'b0;
		end else if (REG_WR && REG_ADDR == `PAE_OFS_MODE_CTL) begin
			pden_q    <= REG_WDATA[`PAE_MODE_PDEN_BIT];
			mode_r0_q <= REG_WDATA[`PAE_MODE_R0_BIT];
		end
	end

	// energy presence, kept across soft reset
	pae_interval u_quiet (.clk(CLK), .rst(RST), .run(energy_q), .restart(LINE_ENERGY),
		.limit(ms_cyc(`PAE_T_ENERGY_MS)), .done(quiet_done));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			energy_q <= 1'b1;
		end else if (LINE_ENERGY) begin
			energy_q <= 1'b1;
		end else if (quiet_done) begin
			energy_q <= 1'b0;
		end
	end

	// power-down state
	pae_interval u_rxwin (.clk(CLK), .rst(RST), .run(pwr_q == PAE_GOT_ONE),
		.restart(1'b0), .limit(rx_limit(cfg_q.wake_pair_iv)), .done(rx_done));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pwr_q <= PAE_AWAKE;
		end else if (SOFT_RST || !pden_q || pden_off) begin
			pwr_q <= PAE_AWAKE;
		end else begin
			case (pwr_q)
				PAE_AWAKE: begin
					if (!energy_q) pwr_q <= PAE_ASLEEP;
				end
				PAE_ASLEEP: begin
					if (LINE_ENERGY && !RX_PULSE) pwr_q <= PAE_AWAKE;
					else if (RX_PULSE && cfg_q.wake_single) pwr_q <= PAE_AWAKE;
					else if (RX_PULSE) pwr_q <= PAE_GOT_ONE;
				end
				PAE_GOT_ONE: begin
					if (RX_PULSE) pwr_q <= PAE_AWAKE;
					else if (rx_done) pwr_q <= PAE_ASLEEP;
				end
				default: pwr_q <= PAE_AWAKE;
			endcase
		end
	end

	// periodic link pulses while asleep
	pae_interval u_txiv (.clk(CLK), .rst(RST), .run(sleeping && cfg_q.pulse_tx_en),
		.restart(1'b0), .limit(tx_limit(cfg_q.pulse_tx_iv)), .done(tx_done));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_pulse_q <= 1'b0;
		end else begin
			tx_pulse_q <= tx_done && sleeping && cfg_q.pulse_tx_en;
		end
	end

	// crossover extension
	pae_interval u_xo (.clk(CLK), .rst(RST), .run(XOVER_ACTIVE && cfg_q.xover_ext),
		.restart(1'b0), .limit(ms_cyc(`PAE_T_XOVER_EXT_MS)), .done(xo_done));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			xext_q <= 1'b0;
		end else if (!XOVER_ACTIVE || !cfg_q.xover_ext || xo_done) begin
			xext_q <= 1'b0;
		end else begin
			xext_q <= 1'b1;
		end
	end

	// read data
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_q <= 16'h0000;
		end else if (REG_RD) begin
			rdata_q <= 16'h0000;
			case (REG_ADDR)
				`PAE_OFS_EXPANSION: begin
					rdata_q[`PAE_EXP_PDF_BIT]  <= pdf_flag || PD_FAULT;
					rdata_q[`PAE_EXP_LPNP_BIT] <= LP_NP_ABLE;
					rdata_q[`PAE_EXP_NP_BIT]   <= `PAE_RST_NP_ABLE;
					rdata_q[`PAE_EXP_PR_BIT]   <= pr_flag || PAGE_RX;
					rdata_q[`PAE_EXP_LPAN_BIT] <= LP_AN_ABLE;
				end
				`PAE_OFS_PULSE_CFG: begin
					rdata_q[`PAE_CFG_TXEN_BIT]  <= cfg_q.pulse_tx_en;
					rdata_q[`PAE_CFG_TXIV_HI:`PAE_CFG_TXIV_LO] <= cfg_q.pulse_tx_iv;
					rdata_q[`PAE_CFG_WAKE1_BIT] <= cfg_q.wake_single;
					rdata_q[`PAE_CFG_RXIV_HI:`PAE_CFG_RXIV_LO] <= cfg_q.wake_pair_iv;
					rdata_q[`PAE_CFG_XOVER_BIT] <= cfg_q.xover_ext;
				end
				`PAE_OFS_MODE_CTL: begin
					rdata_q[`PAE_MODE_PDEN_BIT]  <= pden_q;
					rdata_q[`PAE_MODE_EPRES_BIT] <= energy_q;
					rdata_q[`PAE_MODE_R0_BIT]    <= mode_r0_q;
				end
				`PAE_OFS_INT_SRC: begin
					rdata_q[`PAE_INT_PDF_BIT] <= int_pdf || PD_FAULT;
					rdata_q[`PAE_INT_PR_BIT]  <= int_pr || PAGE_RX;
				end
				default: rdata_q <= 16'h0000;
			endcase
		end
	end

	// outputs from flip-flops
	logic pd_out_q;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pd_out_q <= 1'b0;
		end else begin
			pd_out_q <= sleeping;
		end
	end

	assign REG_RDATA      = rdata_q;
	assign TX_PULSE       = tx_pulse_q;
	assign POWERED_DOWN   = pd_out_q;
	assign XOVER_EXTEND   = xext_q;
	assign ENERGY_PRESENT = energy_q;

	// checks
	a_pdf_latched: assert property (@(posedge CLK) disable iff (RST)
		PD_FAULT |=> pdf_flag) else $error("fault flag not latched");
	a_pr_latched: assert property (@(posedge CLK) disable iff (RST)
		PAGE_RX && !SOFT_RST |=> pr_flag) else $error("page flag not latched");
	a_rd_clears: assert property (@(posedge CLK) disable iff (RST)
		rd_exp && !PD_FAULT |=> !pdf_flag) else $error("read did not clear fault");
	a_int_pdf: assert property (@(posedge CLK) disable iff (RST)
		PD_FAULT |=> int_pdf) else $error("interrupt fault flag missing");
	a_pd_gate: assert property (@(posedge CLK) disable iff (RST)
		!pden_q |-> pwr_q == PAE_AWAKE) else $error("asleep while disabled");
	a_wake_one: assert property (@(posedge CLK) disable iff (RST)
		pwr_q == PAE_ASLEEP && RX_PULSE && cfg_q.wake_single && pden_q && !SOFT_RST
		|=> pwr_q == PAE_AWAKE) else $error("single pulse did not wake");
	a_wake_two: assert property (@(posedge CLK) disable iff (RST)
		pwr_q == PAE_ASLEEP && RX_PULSE && !cfg_q.wake_single && pden_q && !SOFT_RST
		&& !pden_off |=> pwr_q == PAE_GOT_ONE) else $error("first pulse woke device");
	a_tx_gate: assert property (@(posedge CLK) disable iff (RST)
		TX_PULSE |-> $past(cfg_q.pulse_tx_en) && $past(sleeping))
		else $error("pulse sent while not allowed");
	a_energy_set: assert property (@(posedge CLK) disable iff (RST)
		LINE_ENERGY |=> energy_q) else $error("energy not set");
	a_np_zero: assert property (@(posedge CLK) disable iff (RST)
		$past(rd_exp) |-> !REG_RDATA[`PAE_EXP_NP_BIT]) else $error("next page able set");
	c_sleep: cover property (@(posedge CLK) pwr_q == PAE_ASLEEP);
	c_tx: cover property (@(posedge CLK) TX_PULSE);
	c_two: cover property (@(posedge CLK) pwr_q == PAE_GOT_ONE ##1 pwr_q == PAE_AWAKE);
	c_rd_race: cover property (@(posedge CLK) rd_exp && PD_FAULT);
endmodule : pae_regs
`default_nettype wire

//--- verif/pae_partner.sv
/*
 * remote link partner model: line-side events and partner abilities.
 * assumes the block samples these lines on the rising edge of clk.
 */
`default_nettype none
module pae_partner (
	input  wire logic clk,
	output logic      pd_fault,
	output logic      page_rx,
	output logic      lp_np_able,
	output logic      lp_an_able,
	output logic      line_energy,
	output logic      rx_pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{pd_fault, page_rx, lp_np_able, lp_an_able, rx_pulse} = 5'h00;
		line_energy = 1'b1;
	end

	// one-cycle fault or new-page event
	task automatic event_pulse(input logic fault);
		@(posedge clk);
		#1;
		pd_fault = fault;
		page_rx = !fault;
		@(posedge clk);
		#1;
		pd_fault = 1'b0;
		page_rx = 1'b0;
	endtask : event_pulse

	task automatic abilities(input logic np, input logic an);
		@(posedge clk);
		#1;
		lp_np_able = np;
		lp_an_able = an;
	endtask : abilities
endmodule : pae_partner
`default_nettype wire

//--- verif/tb_top.sv
/*
 * self-checking bench for the expansion / power-down register bank.
 * assumes pae_defs.svh on the include path and the partner model.
 */
`default_nettype none
`include "pae_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rst, soft_rst, reg_rd, reg_wr, xover_active;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic        pd_fault, page_rx, lp_np, lp_an, energy, rx_pulse;
	logic        tx_pulse, powered_down, xover_extend, energy_present;
	int          mismatches, compares;

	pae_regs u_pae_regs (.CLK(clk), .RST(rst), .SOFT_RST(soft_rst), .REG_RD(reg_rd),
		.REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_RDATA(reg_rdata), .PD_FAULT(pd_fault), .PAGE_RX(page_rx),
		.LP_NP_ABLE(lp_np), .LP_AN_ABLE(lp_an), .LINE_ENERGY(energy),
		.RX_PULSE(rx_pulse), .XOVER_ACTIVE(xover_active), .TX_PULSE(tx_pulse),
		.POWERED_DOWN(powered_down), .XOVER_EXTEND(xover_extend),
		.ENERGY_PRESENT(energy_present));

	pae_partner u_pae_partner (.clk(clk), .pd_fault(pd_fault), .page_rx(page_rx),
		.lp_np_able(lp_np), .lp_an_able(lp_an), .line_energy(energy),
		.rx_pulse(rx_pulse));

	always #10 clk = ~clk;

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask : wr

	task automatic rdchk(input string name, input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		check(name, d, exp);
	endtask : rdchk

	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	task automatic t_reset;
		rdchk("expansion", `PAE_OFS_EXPANSION, 16'h0000);
		rdchk("pulse_cfg", `PAE_OFS_PULSE_CFG, 16'h0000);
		rdchk("mode_ctl", `PAE_OFS_MODE_CTL, 16'h0002);
		check("energy_present", {15'h0000, energy_present}, 16'h0001);
		rdchk("unmapped", 5'h05, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs;
		wr(`PAE_OFS_PULSE_CFG, 16'hFFFF);
		rdchk("pulse_cfg", `PAE_OFS_PULSE_CFG, 16'hFC01);
		wr(`PAE_OFS_EXPANSION, 16'hFFFF);
		rdchk("expansion", `PAE_OFS_EXPANSION, 16'h0000);
		check("powered_down", {15'h0000, powered_down}, 16'h0000);
		wr(`PAE_OFS_MODE_CTL, 16'hFFFF);
		rdchk("mode_ctl", `PAE_OFS_MODE_CTL, 16'h2003);
		check("powered_down", {15'h0000, powered_down}, 16'h0000);
		check("tx_pulse", {15'h0000, tx_pulse}, 16'h0000);
		$display("test regs done");
	endtask : t_regs

	task automatic t_abil;
		u_pae_partner.abilities(1'b1, 1'b0);
		rdchk("expansion", `PAE_OFS_EXPANSION, 16'h0008);
		u_pae_partner.abilities(1'b0, 1'b1);
		rdchk("expansion", `PAE_OFS_EXPANSION, 16'h0001);
		$display("test abilities done");
	endtask : t_abil

	task automatic t_latch;
		u_pae_partner.event_pulse(1'b0);
		rdchk("expansion", `PAE_OFS_EXPANSION, 16'h0003);
		rdchk("expansion", `PAE_OFS_EXPANSION, 16'h0001);
		rdchk("int_src", `PAE_OFS_INT_SRC, 16'h0002);
		rdchk("int_src", `PAE_OFS_INT_SRC, 16'h0000);
		fork
			rd(`PAE_OFS_EXPANSION, v);
			u_pae_partner.event_pulse(1'b1);
		join
		check("expansion", v, 16'h0011);
		rdchk("expansion", `PAE_OFS_EXPANSION, 16'h0011);
		rdchk("expansion", `PAE_OFS_EXPANSION, 16'h0001);
		rdchk("int_src", `PAE_OFS_INT_SRC, 16'h0004);
		$display("test latch done");
	endtask : t_latch

	task automatic t_soft;
		@(posedge clk);
		#1;
		soft_rst = 1'b1;
		@(posedge clk);
		#1;
		soft_rst = 1'b0;
		rdchk("pulse_cfg", `PAE_OFS_PULSE_CFG, 16'h0000);
		rdchk("mode_ctl", `PAE_OFS_MODE_CTL, 16'h0002);
		check("energy_present", {15'h0000, energy_present}, 16'h0001);
		xover_active = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		check("xover_extend", {15'h0000, xover_extend}, 16'h0000);
		wr(`PAE_OFS_PULSE_CFG, 16'h0001);
		@(posedge clk);
		#1;
		check("xover_extend", {15'h0000, xover_extend}, 16'h0001);
		xover_active = 1'b0;
		@(posedge clk);
		#1;
		check("xover_extend", {15'h0000, xover_extend}, 16'h0000);
		$display("test soft reset done");
	endtask : t_soft

	initial begin
		#(20ns * 5000);
		mismatches++;
		final_report();
	end

	initial begin
		{clk, soft_rst, reg_rd, reg_wr, xover_active} = 5'h00;
		rst = 1'b1;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		mismatches = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_regs();
		t_abil();
		t_latch();
		t_soft();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
